//--- fsc_pin_pkg.sv
package fsc_pin_pkg;

  // Protocol selected for the upper port A lines
  typedef enum logic [2:0]
  {
    MODE_GPIO          = 3'h0,
    MODE_UTOPIA_MASTER = 3'h1,
    MODE_UTOPIA_SLAVE  = 3'h3,
    MODE_MII           = 3'h2,
    MODE_HDLC          = 3'h6
  } proto_mode_e;

  // Transmit cell engine states, Gray along idle -> user -> fill
  typedef enum logic [1:0]
  {
    TX_IDLE = 2'h0,
    TX_USER = 2'h1,
    TX_FILL = 2'h3
  } tx_state_e;

  // Cell length and count limits
  localparam int unsigned CELL_BYTES     = 53;
  localparam logic [5:0]  CELL_LAST      = 6'(CELL_BYTES - 1);
  localparam logic [5:0]  COUNT_RESET    = 6'h00;
  localparam logic [5:0]  COUNT_STEP     = 6'h01;
  localparam logic [7:0]  IDLE_FILL_BYTE = 8'h00;
  localparam logic [7:0]  TXD_RESET      = 8'h00;

  // Vector positions of the four port lines
  localparam int PIN31 = 3;
  localparam int PIN30 = 2;
  localparam int PIN29 = 1;
  localparam int PIN28 = 0;

  // Lines taken by the dedicated function per mode, and their direction (1 = out)
  localparam logic [3:0] MASK_GPIO = 4'h0;
  localparam logic [3:0] MASK_UM   = 4'hF;
  localparam logic [3:0] DIR_UM    = 4'hB;
  localparam logic [3:0] MASK_US   = 4'hD;
  localparam logic [3:0] DIR_US    = 4'h4;
  localparam logic [3:0] MASK_MII  = 4'hF;
  localparam logic [3:0] DIR_MII   = 4'h3;
  localparam logic [3:0] MASK_HDLC = 4'h4;
  localparam logic [3:0] DIR_HDLC  = 4'h4;
  localparam logic [3:0] PIN_RESET = 4'h0;

endpackage : fsc_pin_pkg

//--- port_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none

module port_pin_cell
(
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic out_next,
  input  wire logic oe_next,
  input  wire logic pad_in,
  output var  logic pad_out,
  output var  logic pad_oe,
  output var  logic in_sync
);

  logic stage1_reg;

  // Output and enable flops, two-stage input synchroniser
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      pad_out    <= 1'b0;
      pad_oe     <= 1'b0;
      stage1_reg <= 1'b0;
      in_sync    <= 1'b0;
    end
    else
    begin
      pad_out    <= out_next;
      pad_oe     <= oe_next;
      stage1_reg <= pad_in;
      in_sync    <= stage1_reg;
    end
  end

endmodule : port_pin_cell

`default_nettype wire

//--- fsc_port_a_upper.sv
// Overview of operation
// R1: As UTOPIA master the transmit enable line is driven active whenever the transmit bus holds a valid byte.
// R2: As UTOPIA slave the transmit enable line is an input driven by the external master.
// R3: As UTOPIA slave the transmit cell available line is asserted only when a whole cell can be taken.
// R4: As UTOPIA master the external slave raises transmit cell available when it can take a whole cell.
// R5: In HDLC mode a send request drives request-to-send low and counts as granted once clear-to-send is low.
// R6: As UTOPIA master start of cell is driven with the first byte of each cell.
// R7: In MII mode the transmit error line follows the request to corrupt the frame.
// R8: As UTOPIA master receive enable marks receive data for sampling at the end of the next cycle.
// R9: As UTOPIA slave receive data is enabled only in cycles after receive enable was seen.
// R10: In MII mode the PHY drives the collision input on a collision.
// R11: In MII mode the PHY drives the carrier sense input while the cable is active.
// R12: In MII mode transmit enable stays asserted while transmit data is presented.
// R13: As UTOPIA master with no data pending, idle cells of 53 bytes are sent.
// R14: Each line is general-purpose I/O unless a dedicated function takes it with a fixed direction.
`timescale 1ns/1ps
`default_nettype none

module fsc_port_a_upper
(
  input  wire logic                      clock,
  input  wire logic                      resetn,
  input  wire fsc_pin_pkg::proto_mode_e  mode,
  input  wire logic                      port_a_bit_31_in,
  output var  logic                      port_a_bit_31_out,
  output var  logic                      port_a_bit_31_oe,
  input  wire logic                      port_a_bit_30_in,
  output var  logic                      port_a_bit_30_out,
  output var  logic                      port_a_bit_30_oe,
  input  wire logic                      port_a_bit_29_in,
  output var  logic                      port_a_bit_29_out,
  output var  logic                      port_a_bit_29_oe,
  input  wire logic                      port_a_bit_28_in,
  output var  logic                      port_a_bit_28_out,
  output var  logic                      port_a_bit_28_oe,
  input  wire logic                      clear_to_send_n,
  input  wire logic [3:0]                gpio_out,
  input  wire logic [3:0]                gpio_oe,
  output var  logic [3:0]                gpio_in,
  input  wire logic [7:0]                tx_byte,
  input  wire logic                      tx_byte_valid,
  output var  logic                      tx_byte_ready,
  output var  logic [7:0]                utopia_txd,
  input  wire logic                      cell_room,
  input  wire logic                      rx_accept,
  output var  logic                      rx_sample_strobe,
  output var  logic                      rx_drive_en,
  input  wire logic                      mii_tx_active,
  input  wire logic                      mii_tx_error,
  output var  logic                      mii_collision,
  output var  logic                      mii_carrier,
  input  wire logic                      hdlc_tx_request,
  output var  logic                      hdlc_tx_granted
);
  import fsc_pin_pkg::*;

  logic [3:0] pad_in;
  logic [3:0] pad_out;
  logic [3:0] pad_oe;
  logic [3:0] in_sync;
  logic [3:0] pin_out_next;
  logic [3:0] pin_oe_next;
  logic [3:0] ded_mask;
  logic [3:0] ded_dir;
  logic [3:0] ded_out;
  logic       cts_sync;
  tx_state_e  tx_state_reg;
  tx_state_e  tx_state_next;
  logic [5:0] tx_count_reg;
  logic [5:0] tx_count_next;
  logic [7:0] txd_reg;
  logic [7:0] txd_next;
  logic [7:0] hold_byte_reg;
  logic [7:0] hold_byte_next;
  logic       hold_full_reg;
  logic       hold_full_next;
  logic       ready_reg;
  logic       rx_sample_reg;
  logic       rx_drive_reg;
  logic       collision_reg;
  logic       carrier_reg;
  logic       granted_reg;

  // Mode decode
  wire is_master = (mode == MODE_UTOPIA_MASTER);
  wire is_slave  = (mode == MODE_UTOPIA_SLAVE);
  wire is_mii    = (mode == MODE_MII);
  wire is_hdlc   = (mode == MODE_HDLC);

  // Pin cells: registered drive and two-flop input sampling
  assign pad_in = {port_a_bit_31_in, port_a_bit_30_in, port_a_bit_29_in, port_a_bit_28_in};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_pin
      port_pin_cell u_cell
      (
        .clock    (clock),
        .resetn   (resetn),
        .out_next (pin_out_next[gi]),
        .oe_next  (pin_oe_next[gi]),
        .pad_in   (pad_in[gi]),
        .pad_out  (pad_out[gi]),
        .pad_oe   (pad_oe[gi]),
        .in_sync  (in_sync[gi])
      );
    end
  endgenerate

  // Clear-to-send is a foreign pin, sampled like the port lines
  port_pin_cell u_cts
  (
    .clock    (clock),
    .resetn   (resetn),
    .out_next (1'b0),
    .oe_next  (1'b0),
    .pad_in   (clear_to_send_n),
    .pad_out  (),
    .pad_oe   (),
    .in_sync  (cts_sync)
  );

  // Transmit cell engine decode; cells start only on slave room
  wire clav_sync  = in_sync[PIN30];                                        // R4
  wire cell_start = is_master && (tx_state_reg == TX_IDLE) && clav_sync;
  wire user_send  = is_master && (tx_state_reg == TX_USER) && hold_full_reg;
  wire fill_send  = is_master && (tx_state_reg == TX_FILL);                // R13
  wire tx_send    = cell_start || user_send || fill_send;                  // R1
  wire hold_take  = (cell_start && hold_full_reg) || user_send;
  wire cell_end   = (user_send || fill_send) && (tx_count_reg == CELL_LAST); // R13
  wire hold_load  = tx_byte_valid && ready_reg;

  assign tx_state_next  = (!is_master || cell_end) ? TX_IDLE :
                          cell_start ? (hold_full_reg ? TX_USER : TX_FILL) : tx_state_reg;
  assign tx_count_next  = (!is_master || cell_end) ? COUNT_RESET :
                          tx_send ? 6'(tx_count_reg + COUNT_STEP) : tx_count_reg;
  assign txd_next       = !tx_send ? txd_reg : (hold_take ? hold_byte_reg : IDLE_FILL_BYTE);
  assign hold_full_next = (hold_full_reg && !hold_take) || hold_load;
  assign hold_byte_next = hold_load ? tx_byte : hold_byte_reg;

  // Dedicated function selection per mode
  assign ded_mask = is_master ? MASK_UM : is_slave ? MASK_US : is_mii ? MASK_MII :
                    is_hdlc ? MASK_HDLC : MASK_GPIO;                        // R14
  assign ded_dir  = is_master ? DIR_UM : is_slave ? DIR_US : is_mii ? DIR_MII :
                    is_hdlc ? DIR_HDLC : MASK_GPIO;                         // R2
  assign ded_out  = is_master ? {tx_send, 1'b0, cell_start, rx_accept} :    // R6 R8
                    is_slave  ? {1'b0, cell_room, 2'b00} :                  // R3
                    is_mii    ? {2'b00, mii_tx_error, mii_tx_active} :      // R7 R12
                    is_hdlc   ? {1'b0, !hdlc_tx_request, 2'b00} : PIN_RESET; // R5

  // Free lines fall back to general-purpose I/O
  assign pin_out_next = (ded_mask & ded_dir & ded_out) | (~ded_mask & gpio_out); // R14
  assign pin_oe_next  = (ded_mask & ded_dir) | (~ded_mask & gpio_oe);            // R14

  // Transmit engine and holding byte
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_state_reg  <= TX_IDLE;
      tx_count_reg  <= COUNT_RESET;
      txd_reg       <= TXD_RESET;
      hold_byte_reg <= TXD_RESET;
      hold_full_reg <= 1'b0;
      ready_reg     <= 1'b0;
    end
    else
    begin
      tx_state_reg  <= tx_state_next;
      tx_count_reg  <= tx_count_next;
      txd_reg       <= txd_next;
      hold_byte_reg <= hold_byte_next;
      hold_full_reg <= hold_full_next;
      ready_reg     <= !hold_full_next;
    end
  end

  // Status flops from sampled lines and from the driven receive enable line
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_sample_reg <= 1'b0;
      rx_drive_reg  <= 1'b0;
      collision_reg <= 1'b0;
      carrier_reg   <= 1'b0;
      granted_reg   <= 1'b0;
    end
    else
    begin
      rx_sample_reg <= is_master && pad_oe[PIN28] && pad_out[PIN28];  // R8
      rx_drive_reg  <= is_slave && in_sync[PIN28];                     // R9
      collision_reg <= is_mii && in_sync[PIN31];                       // R10
      carrier_reg   <= is_mii && in_sync[PIN30];                       // R11
      granted_reg   <= is_hdlc && hdlc_tx_request && !cts_sync;        // R5
    end
  end

  // Top-level outputs, all from flops
  assign port_a_bit_31_out = pad_out[PIN31];
  assign port_a_bit_31_oe  = pad_oe[PIN31];
  assign port_a_bit_30_out = pad_out[PIN30];
  assign port_a_bit_30_oe  = pad_oe[PIN30];
  assign port_a_bit_29_out = pad_out[PIN29];
  assign port_a_bit_29_oe  = pad_oe[PIN29];
  assign port_a_bit_28_out = pad_out[PIN28];
  assign port_a_bit_28_oe  = pad_oe[PIN28];
  assign gpio_in           = in_sync;
  assign tx_byte_ready     = ready_reg;
  assign utopia_txd        = txd_reg;
  assign rx_sample_strobe  = rx_sample_reg;
  assign rx_drive_en       = rx_drive_reg;
  assign mii_collision     = collision_reg;
  assign mii_carrier       = carrier_reg;
  assign hdlc_tx_granted   = granted_reg;

  // Checks
  property p_txenb_with_data;
    @(posedge clock) disable iff (!resetn)
    (is_master && hold_take) |=> (pad_out[PIN31] && pad_oe[PIN31]
                                  && utopia_txd == $past(hold_byte_reg));
  endproperty
  a_txenb_with_data: assert property (p_txenb_with_data) else $error("txenb without data"); // R1

  property p_slave_clav;
    @(posedge clock) disable iff (!resetn)
    is_slave |=> (pad_oe[PIN30] && pad_out[PIN30] == $past(cell_room) && !pad_oe[PIN31]);
  endproperty
  a_slave_clav: assert property (p_slave_clav) else $error("slave clav wrong"); // R3

  property p_soc_first;
    @(posedge clock) disable iff (!resetn)
    cell_start |=> (pad_out[PIN29] && pad_out[PIN31] && tx_count_reg == COUNT_STEP);
  endproperty
  a_soc_first: assert property (p_soc_first) else $error("soc not on first byte"); // R6

  // Bytes shown since a fill cell began, counted apart from the engine's own count
  logic [5:0] fill_age_reg;
  logic [5:0] fill_age_next;
  wire fill_begin = cell_start && !hold_full_reg;
  wire fill_open  = (fill_age_reg != COUNT_RESET) && (fill_age_reg != 6'(CELL_BYTES));
  assign fill_age_next = !is_master ? COUNT_RESET :
                         fill_begin ? COUNT_STEP :
                         fill_open  ? 6'(fill_age_reg + COUNT_STEP) : COUNT_RESET;

  // Fill cell length tracker for the check below
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      fill_age_reg <= COUNT_RESET;
    else
      fill_age_reg <= fill_age_next;
  end

  property p_fill_cell;
    @(posedge clock) disable iff (!resetn)
    (fill_age_reg != COUNT_RESET) |-> (pad_out[PIN31] && utopia_txd == IDLE_FILL_BYTE
      && ((fill_age_reg == 6'(CELL_BYTES)) == (tx_state_reg == TX_IDLE)));
  endproperty
  a_fill_cell: assert property (p_fill_cell) else $error("idle cell not 53 bytes"); // R13

  property p_rxenb_sample;
    @(posedge clock) disable iff (!resetn)
    (is_master && rx_accept) ##1 is_master |=> rx_sample_strobe;
  endproperty
  a_rxenb_sample: assert property (p_rxenb_sample) else $error("no sample after rxenb"); // R8

  property p_slave_drive;
    @(posedge clock) disable iff (!resetn)
    $rose(rx_drive_en) |-> $past(in_sync[PIN28]);
  endproperty
  a_slave_drive: assert property (p_slave_drive) else $error("drive without rxenb"); // R9

  property p_mii_txen;
    @(posedge clock) disable iff (!resetn)
    (is_mii && mii_tx_active) |=> (port_a_bit_28_out && port_a_bit_28_oe);
  endproperty
  a_mii_txen: assert property (p_mii_txen) else $error("mii txen dropped"); // R12

  property p_mii_txer;
    @(posedge clock) disable iff (!resetn)
    is_mii |=> (port_a_bit_29_out == $past(mii_tx_error) && port_a_bit_29_oe);
  endproperty
  a_mii_txer: assert property (p_mii_txer) else $error("mii txer wrong"); // R7

  property p_rts_grant;
    @(posedge clock) disable iff (!resetn)
    (is_hdlc && hdlc_tx_request) ##1 (is_hdlc && hdlc_tx_request)
      |-> (!port_a_bit_30_out && port_a_bit_30_oe) ##1 (hdlc_tx_granted == !$past(cts_sync));
  endproperty
  a_rts_grant: assert property (p_rts_grant) else $error("rts or grant wrong"); // R5

  property p_gpio_pass;
    @(posedge clock) disable iff (!resetn)
    (mode == MODE_GPIO) |=> (pad_oe == $past(gpio_oe) && pad_out == $past(gpio_out));
  endproperty
  a_gpio_pass: assert property (p_gpio_pass) else $error("gpio not passed"); // R14

endmodule : fsc_port_a_upper

`default_nettype wire

//--- far_end_phy.sv
`timescale 1ns/1ps
`default_nettype none

module far_end_phy
(
  input  wire logic                     clock,
  input  wire logic                     resetn,
  input  wire fsc_pin_pkg::proto_mode_e mode,
  input  wire logic [3:0]               pad_out,
  input  wire logic [3:0]               pad_oe,
  input  wire logic                     clav_ok,
  input  wire logic                     txenb_on,
  input  wire logic                     rxenb_on,
  input  wire logic                     col_on,
  input  wire logic                     crs_on,
  output var  logic [3:0]               pad_level,
  output var  logic                     clear_to_send_n
);
  import fsc_pin_pkg::*;

  logic [3:0] far_oe;
  logic [3:0] far_val;
  logic [3:0] churn_reg;
  logic [1:0] cts_lag_reg;
  logic       rts_seen;

  // Lines the far side owns in each mode
  assign far_oe[PIN31] = (mode == MODE_MII) || (mode == MODE_UTOPIA_SLAVE);
  assign far_oe[PIN30] = (mode == MODE_MII) || (mode == MODE_UTOPIA_MASTER);
  assign far_oe[PIN29] = 1'b0;
  assign far_oe[PIN28] = (mode == MODE_UTOPIA_SLAVE);
  assign far_val[PIN31] = (mode == MODE_MII) ? col_on : txenb_on;
  assign far_val[PIN30] = (mode == MODE_MII) ? crs_on : clav_ok;
  assign far_val[PIN29] = 1'b0;
  assign far_val[PIN28] = rxenb_on;
  // Undriven lines churn so a stale value never passes for a real one
  assign pad_level = (pad_oe & pad_out) | (~pad_oe & far_oe & far_val)
                   | (~pad_oe & ~far_oe & churn_reg);
  // Modem answers a low request-to-send with clear-to-send low, two cycles on
  assign rts_seen = (mode == MODE_HDLC) && pad_oe[PIN30] && !pad_out[PIN30];
  assign clear_to_send_n = !cts_lag_reg[1];

  // Churn pattern and answer delay line
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      churn_reg   <= 4'h5;
      cts_lag_reg <= 2'h0;
    end
    else
    begin
      churn_reg   <= ~churn_reg;
      cts_lag_reg <= {cts_lag_reg[0], rts_seen};
    end
  end

endmodule : far_end_phy

`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import fsc_pin_pkg::*;

  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  proto_mode_e mode = MODE_GPIO;
  logic [3:0]  p_out, p_oe, lvl, gpio_in;
  logic [3:0]  gpio_out = 4'h0, gpio_oe = 4'h0;
  logic [7:0]  tx_byte = 8'h00, utopia_txd;
  logic        tx_byte_valid = 0, cell_room = 0, rx_accept = 0, mii_tx_active = 0;
  logic        mii_tx_error = 0, hdlc_tx_request = 0, clav_ok = 0, txenb_on = 0;
  logic        rxenb_on = 0, col_on = 0, crs_on = 0;
  logic        cts_n, tx_byte_ready, rx_sample_strobe, rx_drive_en;
  logic        mii_collision, mii_carrier, hdlc_tx_granted;
  int          bad_count = 0, checked = 0, cycles = 0;

  // Design and far side
  fsc_port_a_upper DUT (.clock(clock), .resetn(resetn), .mode(mode),
    .port_a_bit_31_in(lvl[3]), .port_a_bit_31_out(p_out[3]), .port_a_bit_31_oe(p_oe[3]),
    .port_a_bit_30_in(lvl[2]), .port_a_bit_30_out(p_out[2]), .port_a_bit_30_oe(p_oe[2]),
    .port_a_bit_29_in(lvl[1]), .port_a_bit_29_out(p_out[1]), .port_a_bit_29_oe(p_oe[1]),
    .port_a_bit_28_in(lvl[0]), .port_a_bit_28_out(p_out[0]), .port_a_bit_28_oe(p_oe[0]),
    .clear_to_send_n(cts_n), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
    .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid), .tx_byte_ready(tx_byte_ready),
    .utopia_txd(utopia_txd), .cell_room(cell_room), .rx_accept(rx_accept),
    .rx_sample_strobe(rx_sample_strobe), .rx_drive_en(rx_drive_en),
    .mii_tx_active(mii_tx_active), .mii_tx_error(mii_tx_error),
    .mii_collision(mii_collision), .mii_carrier(mii_carrier),
    .hdlc_tx_request(hdlc_tx_request), .hdlc_tx_granted(hdlc_tx_granted));
  far_end_phy phy (.clock(clock), .resetn(resetn), .mode(mode), .pad_out(p_out),
    .pad_oe(p_oe), .clav_ok(clav_ok), .txenb_on(txenb_on), .rxenb_on(rxenb_on),
    .col_on(col_on), .crs_on(crs_on), .pad_level(lvl), .clear_to_send_n(cts_n));

  // Clock and hang guard
  always #25 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    if (got !== exp)
      bad_count++;
  endtask : chk

  // Let n rising edges pass, then sample at the falling edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask : cyc

  task automatic t_gpio();
    @(posedge clock);
    gpio_oe  <= 4'hF;
    gpio_out <= 4'hA;
    cyc(1);
    chk({p_oe, p_out}, 8'hFA);
    cyc(3);
    chk({4'h0, gpio_in}, 8'h0A);
  endtask : t_gpio

  task automatic t_mii();
    @(posedge clock);
    mode          <= MODE_MII;
    mii_tx_active <= 1'b1;
    mii_tx_error  <= 1'b1;
    col_on        <= 1'b1;
    cyc(1);
    chk({p_oe, 2'b00, p_out[1:0]}, 8'h33);
    cyc(3);
    chk({6'h00, mii_collision, mii_carrier}, 8'h02);
    @(posedge clock);
    mii_tx_active <= 1'b0;
    mii_tx_error  <= 1'b0;
    col_on        <= 1'b0;
    crs_on        <= 1'b1;
    cyc(4);
    chk({4'h0, mii_collision, mii_carrier, p_out[1:0]}, 8'h04);
  endtask : t_mii

  task automatic t_hdlc();
    @(posedge clock);
    mode            <= MODE_HDLC;
    hdlc_tx_request <= 1'b1;
    cyc(1);
    chk({5'h00, p_oe[2], p_out[2], hdlc_tx_granted}, 8'h04);
    cyc(8);
    chk({7'h00, hdlc_tx_granted}, 8'h01);
    @(posedge clock);
    hdlc_tx_request <= 1'b0;
    cyc(2);
    chk({6'h00, p_out[2], hdlc_tx_granted}, 8'h02);
  endtask : t_hdlc

  // User byte held first, then the slave opens: one byte with start-of-cell, then a stall
  task automatic t_um_user();
    int i;
    // Park the cell-available line low first so no stale level starts a cell
    @(posedge clock);
    mode          <= MODE_GPIO;
    cyc(3);
    @(posedge clock);
    mode          <= MODE_UTOPIA_MASTER;
    tx_byte       <= 8'hC3;
    tx_byte_valid <= 1'b1;
    @(negedge clock);
    for (i = 0; i < 20 && tx_byte_ready !== 1'b0; i++) @(negedge clock);
    chk({7'h00, tx_byte_ready}, 8'h00);
    @(posedge clock);
    tx_byte_valid <= 1'b0;
    clav_ok       <= 1'b1;
    @(negedge clock);
    for (i = 0; i < 20 && p_out[1] !== 1'b1; i++) @(negedge clock);
    chk(utopia_txd, 8'hC3);
    chk({6'h00, p_oe[3], p_out[3]}, 8'h03);
    @(negedge clock);
    chk({5'h00, tx_byte_ready, p_out[3], p_out[1]}, 8'h04);
  endtask : t_um_user

  // Abort, then idle fill cells back to back: 53 bytes of zero, enable high throughout
  task automatic t_fill();
    int i;
    int lo;
    @(posedge clock);
    mode <= MODE_GPIO;
    cyc(1);
    @(posedge clock);
    mode <= MODE_UTOPIA_MASTER;
    cyc(1);
    for (i = 0; i < 20 && p_out[1] !== 1'b1; i++) @(negedge clock);
    chk(utopia_txd, IDLE_FILL_BYTE);
    i  = 0;
    lo = 0;
    do
    begin
      @(negedge clock);
      i++;
      if (p_out[3] !== 1'b1)
        lo++;
    end while (p_out[1] !== 1'b1 && i < 60);
    chk(8'(i), 8'h35);
    chk(8'(lo), 8'h00);
    @(posedge clock);
    clav_ok <= 1'b0;
  endtask : t_fill

  task automatic t_um_rx();
    @(posedge clock);
    rx_accept <= 1'b1;
    cyc(1);
    chk({5'h00, p_oe[0], p_out[0], rx_sample_strobe}, 8'h06);
    @(posedge clock);
    rx_accept <= 1'b0;
    cyc(1);
    chk({6'h00, p_out[0], rx_sample_strobe}, 8'h01);
  endtask : t_um_rx

  task automatic t_slave();
    @(posedge clock);
    mode      <= MODE_UTOPIA_SLAVE;
    cell_room <= 1'b1;
    cyc(1);
    chk({4'h0, p_oe[3], p_oe[2], p_out[2], p_oe[0]}, 8'h06);
    @(posedge clock);
    rxenb_on <= 1'b1;
    txenb_on <= 1'b1;
    cyc(2);
    chk({6'h00, gpio_in[3], rx_drive_en}, 8'h02);
    @(negedge clock);
    chk({7'h00, rx_drive_en}, 8'h01);
    @(posedge clock);
    cell_room <= 1'b0;
    cyc(1);
    chk({7'h00, p_out[2]}, 8'h00);
  endtask : t_slave

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial
  begin
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    t_gpio();
    t_mii();
    t_hdlc();
    t_um_user();
    t_fill();
    t_um_rx();
    t_slave();
    wrap_up();
  end

endmodule : testbench

`default_nettype wire
